/* File: hw/gpib_cfg.svh */
// constants for the instrument-side bus interface block
// assumes one 40 MHz clock and AXI4-Lite register access
// How it works
// RQ1 - bus trigger and trigger program code both fire the preselected trigger action
// RQ2 - device clear or selected clear pulses the preset-output request
// RQ3 - remote needs REN plus first listen addressing; keyboard stays active before
// RQ4 - remote lamp lights only in remote after a data message arrived
// RQ5 - addressed lamp lights while talker or listener
// RQ6 - go-to-local or local key returns to local, output unchanged
// RQ7 - local lockout disables the local key
// RQ8 - REN false forces local and cancels lockout
// RQ9 - no controller function; pass and take control ignored
// RQ10 - SRQ asserted when any masked status condition holds
// RQ11 - serial poll while talker returns status byte, bit 7 marks request
// RQ12 - status bits latch until cleared, except bit 1 which follows
// RQ13 - no parallel poll response is ever driven
// RQ14 - interface clear drops talker and listener at once
// RQ15 - only SH1 AH1 T6 L3 SR1 RL1 DC1 DT1 functions exist
// RQ16 - remote mode disables front panel except power, local, status, hidden keys
// RQ17 - listen addressing stops talking; talk addressing stops listening
// RQ18 - local to remote keeps output and settings
// RQ19 - data messages rejected in local; other messages still served
// RQ20 - local key works only without lockout, settings unchanged
// RQ21 - controller should send local lockout before data messages
// RQ22 - turn-on: local, immediate mode, unaddressed, switch address, sweep off
// RQ23 - data message ends on line feed, exclamation, END or internal terminator
`ifndef GPIB_CFG_SVH
`define GPIB_CFG_SVH
`define GPIB_REG_CTRL 4'h0
`define GPIB_REG_STAT 4'h4
`define GPIB_REG_MASK 4'h8
`define GPIB_REG_CLR 4'hC
`define GPIB_CTRL_INTEOS 0
`define GPIB_CTRL_DEFER 1
`define GPIB_MASK_RST 8'h00
`define GPIB_CMD_GTL 7'h01
`define GPIB_CMD_SDC 7'h04
`define GPIB_CMD_PPC 7'h05
`define GPIB_CMD_GET 7'h08
`define GPIB_CMD_TCT 7'h09
`define GPIB_CMD_LLO 7'h11
`define GPIB_CMD_DCL 7'h14
`define GPIB_CMD_SPE 7'h18
`define GPIB_CMD_SPD 7'h19
`define GPIB_CMD_UNL 7'h3F
`define GPIB_CMD_UNT 7'h5F
`define GPIB_LAG_BASE 2'b01
`define GPIB_TAG_BASE 2'b10
`define GPIB_CH_LF 8'h0A
`define GPIB_CH_EXCL 8'h21
`define GPIB_CH_TRIG0 8'h54
`define GPIB_CH_TRIG1 8'h52
`define GPIB_SB_RQS 7
`define GPIB_SB_FOLLOW 1
`define GPIB_AXI_OKAY 2'b00
`define GPIB_AXI_SLVERR 2'b10
`endif

/* File: hw/gpib_pkg.sv */
// types for the instrument-side bus interface block
// assumes gpib_cfg.svh is included by the design files
package gpib_pkg;
   typedef enum logic [1:0] {
      GPIB_LOCS,
      GPIB_REMS,
      GPIB_LWLS,
      GPIB_RWLS
   } gpib_rl_t;
   typedef enum logic [1:0] {
      GPIB_AX_IDLE,
      GPIB_AX_RESP
   } gpib_ax_t;
endpackage

/* File: hw/gpib_term.sv */
// data byte terminator and trigger code detector
// assumes bytes arrive as one-cycle strobes from the handshake
`timescale 1ns/1ps
`default_nettype none
`include "gpib_cfg.svh"
module gpib_term (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // accepted data byte
   input wire logic i_stb,
   input wire logic [7:0] i_byte,
   input wire logic i_end,
   input wire logic i_int_eos,
   // results
   output logic o_term,
   output logic o_trig
);
   logic prev_t_q;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prev_t_q <= 1'b0;
      end else if (i_stb) begin
         prev_t_q <= (i_byte & 8'hDF) == `GPIB_CH_TRIG0;
      end
   end
   always_comb begin
      o_term = i_int_eos || (i_stb && (i_end || i_byte == `GPIB_CH_LF
               || i_byte == `GPIB_CH_EXCL)); // see RQ23
      o_trig = i_stb && prev_t_q && (i_byte & 8'hDF) == `GPIB_CH_TRIG1; // see RQ1
   end
endmodule // gpib_term
`default_nettype wire

/* File: hw/gpib_stat.sv */
// status byte latches
// assumes condition inputs are levels sampled each cycle
`timescale 1ns/1ps
`default_nettype none
`include "gpib_cfg.svh"
module gpib_stat (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // conditions and clears
   input wire logic [7:0] i_cond,
   input wire logic [7:0] i_clr,
   // latched byte
   output logic [7:0] o_stat
);
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_bit
         if (b == `GPIB_SB_FOLLOW) begin : g_follow
            always_ff @(posedge i_clk or posedge i_rst) begin
               if (i_rst) begin
                  o_stat[b] <= 1'b0;
               end else begin
                  o_stat[b] <= i_cond[b]; // see RQ12
               end
            end
         end else begin : g_latch
            always_ff @(posedge i_clk or posedge i_rst) begin
               if (i_rst) begin
                  o_stat[b] <= 1'b0;
               end else if (i_cond[b]) begin
                  o_stat[b] <= 1'b1; // see RQ12
               end else if (i_clr[b]) begin
                  o_stat[b] <= 1'b0;
               end
            end
         end
      end
   endgenerate
endmodule // gpib_stat
`default_nettype wire

/* File: hw/gpib_top.sv */
// bus interface logic of the instrument: addressing, remote/local, polls
// assumes bus lines and handshake-decoded bytes are synchronous to I_CLK_SYS
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "gpib_cfg.svh"
module gpib_top (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   // bus management lines
   input wire logic I_REN,
   input wire logic I_IFC,
   input wire logic I_ATN,
   // accepted byte from acceptor handshake
   input wire logic I_BYTE_STB,
   input wire logic [7:0] I_BYTE,
   input wire logic I_EOI,
   // address switch and front panel
   input wire logic [4:0] I_ADDR_SW,
   input wire logic I_LOCAL_KEY,
   input wire logic I_INT_EOS,
   // status conditions: 0 ready 1 follow 2 entry err 3 hw err 4 pwr 5 param 6 sweep
   input wire logic [6:0] I_COND,
   input wire logic [6:0] I_COND_CLR,
   // bus outputs
   output logic O_SRQ,
   output logic [7:0] O_TX_BYTE,
   output logic O_TX_VALID,
   output logic O_PP_DRIVE,
   // instrument controls
   output logic O_REMOTE_LAMP,
   output logic O_ADDR_LAMP,
   output logic O_PANEL_LOCK,
   output logic O_DATA_STB,
   output logic [7:0] O_DATA,
   output logic O_DATA_END,
   output logic O_TRIGGER,
   output logic O_PRESET,
   output logic O_DEFER_MODE,
   // axi4-lite write address
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // axi4-lite write data
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   gpib_pkg::gpib_rl_t rl_q;
   logic [4:0] addr_q;
   logic addr_ld_q;
   logic lad_q, tad_q, spe_q, got_data_q, srq_sent_q;
   logic [7:0] mask_q;
   logic [1:0] ctrl_q;
   logic [7:0] stat;
   logic [7:0] cond_all, clr_all;
   logic cmd, dab, term, code_trig, remote, lockout, srq_any;
   logic [6:0] cmd_code;
   logic my_lad, my_tad;
   logic aw_hold_q, w_hold_q;
   logic [3:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   assign cmd = I_BYTE_STB && I_ATN;
   assign dab = I_BYTE_STB && !I_ATN;
   assign cmd_code = I_BYTE[6:0];
   assign my_lad = cmd && cmd_code == {`GPIB_LAG_BASE, addr_q};
   assign my_tad = cmd && cmd_code == {`GPIB_TAG_BASE, addr_q};
   assign remote = rl_q == gpib_pkg::GPIB_REMS || rl_q == gpib_pkg::GPIB_RWLS;
   assign lockout = rl_q == gpib_pkg::GPIB_LWLS || rl_q == gpib_pkg::GPIB_RWLS;

   gpib_term u_term (
      .i_clk(I_CLK_SYS),
      .i_rst(I_SYS_RST),
      .i_stb(dab && lad_q && remote),
      .i_byte(I_BYTE),
      .i_end(I_EOI),
      .i_int_eos(I_INT_EOS && ctrl_q[`GPIB_CTRL_INTEOS]),
      .o_term(term),
      .o_trig(code_trig)
   );

   assign cond_all = {1'b0, I_COND};
   assign clr_all = {1'b0, I_COND_CLR};
   gpib_stat u_stat (
      .i_clk(I_CLK_SYS),
      .i_rst(I_SYS_RST),
      .i_cond(cond_all),
      .i_clr(clr_all),
      .o_stat(stat)
   );
   assign srq_any = |(stat[6:0] & mask_q[6:0]); // see RQ10

   // switch address taken once after reset release
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         addr_q <= 5'h00;
         addr_ld_q <= 1'b0;
      end else if (!addr_ld_q) begin
         addr_q <= I_ADDR_SW; // see RQ22
         addr_ld_q <= 1'b1;
      end
   end

   // talker and listener addressing; no controller functions decoded
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         lad_q <= 1'b0; // see RQ22
         tad_q <= 1'b0;
      end else if (I_IFC) begin
         lad_q <= 1'b0; // see RQ14
         tad_q <= 1'b0;
      end else if (my_lad) begin
         lad_q <= 1'b1;
         tad_q <= 1'b0; // see RQ17
      end else if (my_tad) begin
         tad_q <= 1'b1;
         lad_q <= 1'b0; // see RQ17
      end else if (cmd && cmd_code == `GPIB_CMD_UNL) begin
         lad_q <= 1'b0;
      end else if (cmd && cmd_code == `GPIB_CMD_UNT) begin
         tad_q <= 1'b0;
      end
   end

   // serial poll mode
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         spe_q <= 1'b0;
      end else if (I_IFC || (cmd && cmd_code == `GPIB_CMD_SPD)) begin
         spe_q <= 1'b0;
      end else if (cmd && cmd_code == `GPIB_CMD_SPE) begin
         spe_q <= 1'b1;
      end
   end

   // remote/local machine; pass and take control codes fall through unused
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         rl_q <= gpib_pkg::GPIB_LOCS; // see RQ22
      end else if (!I_REN) begin
         rl_q <= gpib_pkg::GPIB_LOCS; // see RQ8
      end else begin
         unique case (rl_q)
            gpib_pkg::GPIB_LOCS: begin
               if (cmd && cmd_code == `GPIB_CMD_LLO) begin
                  rl_q <= gpib_pkg::GPIB_LWLS;
               end else if (my_lad) begin
                  rl_q <= gpib_pkg::GPIB_REMS; // see RQ3, RQ18
               end
            end
            gpib_pkg::GPIB_REMS: begin
               if (cmd && cmd_code == `GPIB_CMD_LLO) begin
                  rl_q <= gpib_pkg::GPIB_RWLS;
               end else if ((lad_q && cmd && cmd_code == `GPIB_CMD_GTL) || I_LOCAL_KEY) begin
                  rl_q <= gpib_pkg::GPIB_LOCS; // see RQ6, RQ20
               end
            end
            gpib_pkg::GPIB_LWLS: begin
               if (my_lad) begin
                  rl_q <= gpib_pkg::GPIB_RWLS;
               end
            end
            gpib_pkg::GPIB_RWLS: begin
               if (lad_q && cmd && cmd_code == `GPIB_CMD_GTL) begin
                  rl_q <= gpib_pkg::GPIB_LWLS; // see RQ7, RQ6
               end
            end
         endcase
      end
   end

   // remote lamp qualifier: first data message since entering remote
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         got_data_q <= 1'b0;
      end else if (!remote) begin
         got_data_q <= 1'b0;
      end else if (dab && lad_q) begin
         got_data_q <= 1'b1; // see RQ4
      end
   end

   // data path to program-code parser; rejected in local
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_DATA_STB <= 1'b0;
         O_DATA <= 8'h00;
         O_DATA_END <= 1'b0;
      end else begin
         O_DATA_STB <= dab && lad_q && remote; // see RQ19
         O_DATA <= I_BYTE;
         O_DATA_END <= term; // see RQ23
      end
   end

   // trigger and clear actions
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_TRIGGER <= 1'b0;
         O_PRESET <= 1'b0;
      end else begin
         O_TRIGGER <= (cmd && lad_q && cmd_code == `GPIB_CMD_GET) || code_trig; // see RQ1
         O_PRESET <= cmd && (cmd_code == `GPIB_CMD_DCL
                     || (lad_q && cmd_code == `GPIB_CMD_SDC)); // see RQ2
      end
   end

   // service request and poll answer; remembers that a request went out
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         srq_sent_q <= 1'b0;
         O_SRQ <= 1'b0;
         O_TX_BYTE <= 8'h00;
         O_TX_VALID <= 1'b0;
      end else begin
         O_SRQ <= srq_any; // see RQ10
         if (srq_any) begin
            srq_sent_q <= 1'b1;
         end else if (spe_q && tad_q && O_TX_VALID) begin
            srq_sent_q <= 1'b0;
         end
         O_TX_VALID <= spe_q && tad_q && !I_IFC; // see RQ11
         O_TX_BYTE <= {srq_sent_q || srq_any, stat[6:0]}; // see RQ11
      end
   end

   // lamps, panel lock, parallel poll line
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_REMOTE_LAMP <= 1'b0;
         O_ADDR_LAMP <= 1'b0;
         O_PANEL_LOCK <= 1'b0;
         O_PP_DRIVE <= 1'b0;
      end else begin
         O_REMOTE_LAMP <= remote && got_data_q; // see RQ4
         O_ADDR_LAMP <= lad_q || tad_q; // see RQ5
         O_PANEL_LOCK <= remote; // see RQ16
         O_PP_DRIVE <= 1'b0; // see RQ13, RQ9, RQ15
      end
   end

   // axi4-lite write side: address and data taken in either order
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `GPIB_AXI_OKAY;
         mask_q <= `GPIB_MASK_RST;
         ctrl_q <= 2'b00; // see RQ22
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
         if (aw_hold_q && w_hold_q && !S_AXI_BVALID) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= `GPIB_AXI_OKAY;
            if (aw_addr_q == `GPIB_REG_MASK && w_strb_q[0]) begin
               mask_q <= w_data_q[7:0];
            end else if (aw_addr_q == `GPIB_REG_CTRL && w_strb_q[0]) begin
               ctrl_q <= w_data_q[1:0];
            end else if (aw_addr_q != `GPIB_REG_MASK && aw_addr_q != `GPIB_REG_CTRL) begin
               S_AXI_BRESP <= `GPIB_AXI_SLVERR;
            end
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end
   assign S_AXI_AWREADY = !aw_hold_q && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_hold_q && !S_AXI_BVALID;

   // axi4-lite read side
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= `GPIB_AXI_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= `GPIB_AXI_OKAY;
         unique case (S_AXI_ARADDR)
            `GPIB_REG_CTRL: S_AXI_RDATA <= {30'h0, ctrl_q};
            `GPIB_REG_MASK: S_AXI_RDATA <= {24'h0, mask_q};
            `GPIB_REG_STAT: S_AXI_RDATA <= {16'h0, stat, 1'b0, spe_q, got_data_q,
                                           lad_q, tad_q, lockout, remote, srq_sent_q};
            default: begin
               S_AXI_RDATA <= 32'h0000_0000;
               S_AXI_RRESP <= `GPIB_AXI_SLVERR;
            end
         endcase
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   assign O_DEFER_MODE = ctrl_q[`GPIB_CTRL_DEFER];
endmodule // gpib_top
`default_nettype wire

/* File: bench/gpib_top_monitor.sv */
// checker of the bus interface top ports
// assumes one clock domain and the design constants header
`timescale 1ns/1ps
`default_nettype none
`include "gpib_cfg.svh"
module gpib_mon (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   // bus inputs
   input wire logic I_REN,
   input wire logic I_IFC,
   input wire logic I_ATN,
   input wire logic I_BYTE_STB,
   input wire logic [7:0] I_BYTE,
   // watched outputs
   input wire logic O_PP_DRIVE,
   input wire logic O_REMOTE_LAMP,
   input wire logic O_ADDR_LAMP,
   input wire logic O_PANEL_LOCK,
   input wire logic O_DATA_STB,
   input wire logic O_TRIGGER,
   input wire logic O_PRESET
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_SYS_RST);
   property p_no_pp;
      O_PP_DRIVE == 1'b0;
   endproperty
   a_no_pp: assert property (p_no_pp) else $error("poll bit driven");
   property p_ren_off;
      !I_REN [*3] |-> !O_PANEL_LOCK && !O_REMOTE_LAMP;
   endproperty
   a_ren_off: assert property (p_ren_off) else $error("remote without enable");
   property p_ifc;
      I_IFC [*3] |-> !O_ADDR_LAMP;
   endproperty
   a_ifc: assert property (p_ifc) else $error("addressed after clear");
   property p_data;
      O_DATA_STB |-> $past(I_BYTE_STB) && !$past(I_ATN) && $past(I_REN);
   endproperty
   a_data: assert property (p_data) else $error("data without byte");
   property p_rlamp;
      O_REMOTE_LAMP |-> $past(I_REN, 2);
   endproperty
   a_rlamp: assert property (p_rlamp) else $error("remote lamp in local");
   property p_lock;
      $rose(O_PANEL_LOCK) |-> $past(I_BYTE_STB) || $past(I_BYTE_STB, 2);
   endproperty
   a_lock: assert property (p_lock) else $error("remote without address");
   property p_preset;
      O_PRESET |-> $past(I_BYTE_STB) && $past(I_ATN) &&
         ($past(I_BYTE[6:0]) == `GPIB_CMD_DCL || $past(I_BYTE[6:0]) == `GPIB_CMD_SDC);
   endproperty
   a_preset: assert property (p_preset) else $error("preset without clear");
   property p_trig;
      O_TRIGGER |-> $past(I_BYTE_STB) || $past(I_BYTE_STB, 2);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger without byte");
   property p_alamp;
      $rose(O_ADDR_LAMP) |-> ($past(I_BYTE_STB) && $past(I_ATN)) ||
         ($past(I_BYTE_STB, 2) && $past(I_ATN, 2));
   endproperty
   a_alamp: assert property (p_alamp) else $error("lamp without address");
endmodule // gpib_mon
bind gpib_top gpib_mon mon_u (
   .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_REN(I_REN), .I_IFC(I_IFC),
   .I_ATN(I_ATN), .I_BYTE_STB(I_BYTE_STB), .I_BYTE(I_BYTE), .O_PP_DRIVE(O_PP_DRIVE),
   .O_REMOTE_LAMP(O_REMOTE_LAMP), .O_ADDR_LAMP(O_ADDR_LAMP), .O_PANEL_LOCK(O_PANEL_LOCK),
   .O_DATA_STB(O_DATA_STB), .O_TRIGGER(O_TRIGGER), .O_PRESET(O_PRESET)
);
`default_nettype wire

/* File: bench/gpib_ctl_model.sv */
// bus controller model: management lines and accepted byte strobes
// assumes the acceptor handshake is reduced to a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
module gpib_ctl_model (
   // clock
   input wire logic i_clk,
   // bus lines
   output logic o_ren = 1'b0,
   output logic o_ifc = 1'b0,
   output logic o_atn = 1'b0,
   output logic o_stb = 1'b0,
   output logic [7:0] o_byte = 8'h00,
   output logic o_eoi = 1'b0
);
   task automatic lines(input logic r, input logic f);
      @(posedge i_clk);
      o_ren <= r;
      o_ifc <= f;
   endtask
   // released data lines show the inverse so a stale byte cannot pass
   task automatic send(input logic a, input logic [7:0] b, input logic e);
      @(posedge i_clk);
      o_atn <= a;
      o_byte <= b;
      o_eoi <= e;
      o_stb <= 1'b1;
      @(posedge i_clk);
      o_stb <= 1'b0;
      o_byte <= ~b;
      o_eoi <= 1'b0;
   endtask
   task automatic msg(input string s);
      send(1'b1, 8'h11, 1'b0);
      foreach (s[i]) begin
         send(1'b0, s[i], 1'b0);
      end
      send(1'b0, 8'h0A, 1'b0);
   endtask
endmodule // gpib_ctl_model
`default_nettype wire

/* File: bench/ieee488_remote_interface_tb.sv */
// bench of the bus interface top: bus traffic, front panel and registers
// assumes the controller model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "gpib_cfg.svh"
module ieee488_remote_interface_tb;
   localparam logic [7:0] la = 8'h2B;
   localparam logic [7:0] ta = 8'h4B;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic key = 1'b0;
   logic [6:0] cond = 7'h00;
   logic [6:0] clr = 7'h00;
   logic string_terminator = 1'b0;
   logic defer;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic ren, ifc, atn, stb, eoi, srq, txv, ppd, rlamp, alamp, lock, dstb, dend, trig, pre;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] byt, txb, dat;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, rd_q, rs_q;
   int fail_count = 0;
   int n_compared = 0;
   int n_data = 0;
   int n_trig = 0;
   int n_pre = 0;
   int n_end = 0;
   int ncyc = 0;
   always #12.5 clk = ~clk;
   gpib_ctl_model ctl_u (.i_clk(clk), .o_ren(ren), .o_ifc(ifc), .o_atn(atn), .o_stb(stb),
      .o_byte(byt), .o_eoi(eoi));
   gpib_top dut_u (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_REN(ren), .I_IFC(ifc), .I_ATN(atn),
      .I_BYTE_STB(stb), .I_BYTE(byt), .I_EOI(eoi), .I_ADDR_SW(5'h0B), .I_LOCAL_KEY(key),
      .I_INT_EOS(string_terminator), .I_COND(cond), .I_COND_CLR(clr), .O_SRQ(srq), .O_TX_BYTE(txb),
      .O_TX_VALID(txv), .O_PP_DRIVE(ppd), .O_REMOTE_LAMP(rlamp), .O_ADDR_LAMP(alamp),
      .O_PANEL_LOCK(lock), .O_DATA_STB(dstb), .O_DATA(dat), .O_DATA_END(dend),
      .O_TRIGGER(trig), .O_PRESET(pre), .O_DEFER_MODE(defer), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   // line feed is excluded so only payload bytes are counted
   always @(posedge clk) begin
      if (dstb === 1'b1 && dat !== 8'h0A) n_data <= n_data + 1;
      if (trig === 1'b1) n_trig <= n_trig + 1;
      if (pre === 1'b1) n_pre <= n_pre + 1;
      if (dend === 1'b1) n_end <= n_end + 1;
   end
   always @(posedge clk) begin
      ncyc <= ncyc + 1;
      if (ncyc == 5000) begin
         fail_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // ready is read at the falling edge, where it is settled for the next rising edge
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic aw, w, b;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         rs_q = {30'h0, bresp};
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end while (!b);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      logic ar, r;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         ar = arvalid && arready;
         r = rvalid;
         rd_q = rdata;
         rs_q = {30'h0, rresp};
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
      end while (!r);
      rready <= 1'b0;
   endtask
   task automatic bus(input logic a, input logic [7:0] b);
      ctl_u.send(a, b, 1'b0);
      repeat (3) @(negedge clk);
   endtask
   task automatic press();
      @(posedge clk);
      key <= 1'b1;
      @(posedge clk);
      key <= 1'b0;
      repeat (3) @(negedge clk);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(4'h4);
      chk("stat", 32'h0000_0000, rd_q & 32'h0000_005E);
      rd(4'h8);
      chk("mask", 32'h0000_0000, rd_q);
      rd(4'hC);
      chk("resp", 32'h0000_0002, rs_q);
      wr(4'h8, 32'h0000_0004);
      chk("bresp", 32'h0000_0000, rs_q);
      rd(4'h8);
      chk("mask", 32'h0000_0004, rd_q);
      chk("srq", 32'h0, srq);
      ctl_u.lines(1'b1, 1'b0);
      bus(1'b0, 8'h41);
      chk("data", 32'h0, n_data);
      chk("lock", 32'h0, lock);
      bus(1'b1, la);
      chk("lock", 32'h1, lock);
      chk("alamp", 32'h1, alamp);
      chk("rlamp", 32'h0, rlamp);
      press();
      chk("lock", 32'h0, lock);
      bus(1'b1, la);
      ctl_u.msg("TR");
      repeat (3) @(negedge clk);
      chk("data", 32'h2, n_data);
      chk("trig", 32'h1, n_trig);
      chk("end", 32'h1, n_end);
      chk("rlamp", 32'h1, rlamp);
      press();
      chk("lock", 32'h1, lock);
      bus(1'b1, {1'b0, `GPIB_CMD_GET});
      chk("trig", 32'h2, n_trig);
      bus(1'b1, {1'b0, `GPIB_CMD_SDC});
      bus(1'b1, {1'b0, `GPIB_CMD_DCL});
      chk("preset", 32'h2, n_pre);
      bus(1'b1, {1'b0, `GPIB_CMD_PPC});
      bus(1'b1, {1'b0, `GPIB_CMD_TCT});
      chk("pp", 32'h0, ppd);
      rd(4'h4);
      chk("stat", 32'h0000_0016, rd_q & 32'h0000_005E);
      bus(1'b1, {1'b0, `GPIB_CMD_GTL});
      chk("lock", 32'h0, lock);
      chk("rlamp", 32'h0, rlamp);
      chk("alamp", 32'h1, alamp);
      bus(1'b0, 8'h41);
      chk("data", 32'h2, n_data);
      ctl_u.lines(1'b0, 1'b0);
      repeat (3) @(negedge clk);
      rd(4'h4);
      chk("stat", 32'h0000_0000, rd_q & 32'h0000_0006);
      ctl_u.lines(1'b1, 1'b0);
      cond <= 7'h06;
      @(posedge clk);
      cond <= 7'h02;
      bus(1'b1, {1'b0, `GPIB_CMD_SPE});
      bus(1'b1, ta);
      chk("srq", 32'h1, srq);
      chk("txv", 32'h1, txv);
      chk("txb", 32'h0000_0086, txb);
      rd(4'h4);
      chk("stat", 32'h0000_0048, rd_q & 32'h0000_0058);
      @(posedge clk);
      cond <= 7'h00;
      repeat (3) @(negedge clk);
      chk("txb", 32'h0000_0084, txb);
      clr <= 7'h04;
      @(posedge clk);
      clr <= 7'h00;
      repeat (3) @(negedge clk);
      chk("txb", 32'h0000_0000, txb);
      chk("srq", 32'h0, srq);
      bus(1'b1, {1'b0, `GPIB_CMD_SPD});
      chk("txv", 32'h0, txv);
      bus(1'b1, la);
      rd(4'h4);
      chk("stat", 32'h0000_0010, rd_q & 32'h0000_0018);
      wr(4'h0, 32'h0000_0003);
      chk("defer", 32'h1, defer);
      @(posedge clk);
      string_terminator <= 1'b1;
      @(posedge clk);
      string_terminator <= 1'b0;
      repeat (3) @(negedge clk);
      chk("end", 32'h2, n_end);
      ctl_u.lines(1'b1, 1'b1);
      repeat (3) @(posedge clk);
      ctl_u.lines(1'b1, 1'b0);
      repeat (3) @(negedge clk);
      chk("alamp", 32'h0, alamp);
      rd(4'h4);
      chk("stat", 32'h0000_0000, rd_q & 32'h0000_0018);
      end_of_test();
   end
endmodule // ieee488_remote_interface_tb
`default_nettype wire
